// ### rtl/cke_power_map.svh
// timing constants for the cke power-state logic
`ifndef CKE_POWER_MAP_SVH
`define CKE_POWER_MAP_SVH
`define CLK_PERIOD_PS          5000
`define PD_EXIT_TIME_PS        7500
`define PD_EXIT_CYCLES \
  ((`PD_EXIT_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SR_EXIT_LOCK_TIME_PS   75000
`define SR_EXIT_CYCLES \
  ((`SR_EXIT_LOCK_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define REFRESH_PERIOD_NS      7800
`define REFRESH_PERIOD_CYCLES  ((`REFRESH_PERIOD_NS * 1000) / `CLK_PERIOD_PS)
`define REFRESH_MARGIN_CYCLES  4
`define NUM_BANKS              4
`define CNT_W                  12
`endif

// ### rtl/cke_power_pkg.sv
// types shared by both ends of the cke power-state link
package cke_power_pkg;
  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
    CMD_BURST_STOP, CMD_REFRESH, CMD_MRS
  } cmd_t;
  typedef enum logic [2:0] {
    PWR_IDLE, PWR_ACTIVE, PWR_POWER_DOWN, PWR_PD_EXIT, PWR_SELF_REFRESH,
    PWR_SR_EXIT
  } pwr_state_t;
  typedef enum logic [1:0] {
    BANK_IDLE, BANK_OPEN, BANK_PRECHARGING
  } bank_state_t;
endpackage

// ### rtl/cke_power_if.sv
// command and cke link between controller and memory
`timescale 1ns/1ps
interface cke_power_if;
  logic       cke;
  logic       cs_n;
  logic       ras_n;
  logic       cas_n;
  logic       we_n;
  logic [1:0] bank_addr;
  logic       auto_pre;
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank_addr, auto_pre);
  modport mem  (input  cke, cs_n, ras_n, cas_n, we_n, bank_addr, auto_pre);
endinterface

// ### rtl/cke_power_mem.sv
// memory-side cke power-state decoder and bank legality tracker
// Summary of operation
// - normal decode only when cke high twice
// - all banks idle: decode command normally
// - self-refresh entry only from all banks idle; power-down entry also with banks open
// - previous cke low: power-down handling applies
// - cke rise exits power-down, idle or active after delay
// - cke rise in self-refresh wakes receivers
// - controller waits lock time after self-refresh exit
// - legality judged per addressed bank
// - controller respects burst turnaround constraints; here left to the requester
// - precharge of idle bank is no operation
// - refresh and mode set only all idle
// - controller never issues illegal combinations; here it only blocks refresh and mode set with banks open
// - other states use ordinary decode when high
// - self-refresh entry encoding, cke stays low
// - self-refresh exit: nop then hold cke
// - power-down follows cke; only clock receivers live
// - power-down no longer than refresh period
`timescale 1ns/1ps
`include "cke_power_map.svh"
module cke_power_mem
  import cke_power_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  cke_power_if.mem        link,
  output pwr_state_t      pwr_state_out,
  output logic            rx_enabled_out,
  output logic            cmd_valid_out,
  output cmd_t            cmd_out,
  output logic [1:0]      cmd_bank_out,
  output logic            illegal_out,
  output logic [3:0]      bank_open_out
);

  function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                      input logic cas_n, input logic we_n);
    if (cs_n)
      return CMD_DESELECT;
    case ({ras_n, cas_n, we_n})
      3'h7:    return CMD_NOP;
      3'h3:    return CMD_ACTIVE;
      3'h5:    return CMD_READ;
      3'h4:    return CMD_WRITE;
      3'h2:    return CMD_PRECHARGE;
      3'h6:    return CMD_BURST_STOP;
      3'h1:    return CMD_REFRESH;
      default: return CMD_MRS;
    endcase
  endfunction

  logic                 cke_prev_r;
  pwr_state_t           state_r;
  logic [`CNT_W-1:0]    wait_r;
  bank_state_t          bank_r [`NUM_BANKS];
  cmd_t                 cmd;
  logic                 all_idle;
  logic                 nop_like;
  logic                 illegal_nxt;
  logic                 decode_en;

  assign cmd = decode_cmd(link.cs_n, link.ras_n, link.cas_n, link.we_n);
  assign nop_like = (cmd == CMD_DESELECT) || (cmd == CMD_NOP);

  always_comb begin
    all_idle = 1'b1;
    for (int i = 0; i < `NUM_BANKS; i++) begin
      if (bank_r[i] != BANK_IDLE)
        all_idle = 1'b0;
    end
  end

  // ordinary decode needs cke high on both edges
  assign decode_en = cke_prev_r && link.cke &&
                     (state_r == PWR_IDLE || state_r == PWR_ACTIVE);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      cke_prev_r <= 1'b0;
    else
      cke_prev_r <= link.cke;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= PWR_IDLE;
      wait_r  <= '0;
    end else begin
      case (state_r)
        PWR_IDLE, PWR_ACTIVE: begin
          if (cke_prev_r && !link.cke) begin
            if (all_idle && cmd == CMD_REFRESH)
              state_r <= PWR_SELF_REFRESH;
            else if (nop_like)
              state_r <= PWR_POWER_DOWN;
          end else if (!cke_prev_r && link.cke) begin
            state_r <= all_idle ? PWR_IDLE : PWR_ACTIVE;
          end else if (cke_prev_r) begin
            state_r <= all_idle ? PWR_IDLE : PWR_ACTIVE;
          end
        end
        PWR_POWER_DOWN: begin
          if (link.cke) begin
            state_r <= PWR_PD_EXIT;
            wait_r  <= `CNT_W'(`PD_EXIT_CYCLES - 1);
          end
        end
        PWR_PD_EXIT: begin
          if (wait_r == '0)
            state_r <= all_idle ? PWR_IDLE : PWR_ACTIVE;
          else
            wait_r <= wait_r - `CNT_W'(1);
        end
        PWR_SELF_REFRESH: begin
          if (link.cke) begin
            state_r <= PWR_SR_EXIT;
            wait_r  <= `CNT_W'(`SR_EXIT_CYCLES - 1);
          end
        end
        PWR_SR_EXIT: begin
          if (wait_r == '0)
            state_r <= PWR_IDLE;
          else
            wait_r <= wait_r - `CNT_W'(1);
        end
        default: state_r <= PWR_IDLE;
      endcase
    end
  end

  // receivers gated in power-down and self-refresh until cke rises
  assign rx_enabled_out = link.cke ||
                          (state_r != PWR_POWER_DOWN &&
                           state_r != PWR_SELF_REFRESH);

  always_comb begin
    illegal_nxt = 1'b0;
    if (state_r == PWR_IDLE || state_r == PWR_ACTIVE) begin
      if (cke_prev_r && !link.cke) begin
        if (!all_idle)
          illegal_nxt = !nop_like;
        else
          illegal_nxt = !nop_like && cmd != CMD_REFRESH;
      end else if (decode_en) begin
        case (cmd)
          CMD_REFRESH, CMD_MRS: illegal_nxt = !all_idle;
          CMD_READ, CMD_WRITE:
            illegal_nxt = bank_r[link.bank_addr] != BANK_OPEN;
          CMD_ACTIVE:
            illegal_nxt = bank_r[link.bank_addr] != BANK_IDLE;
          default: illegal_nxt = 1'b0;
        endcase
      end
    end else if (state_r == PWR_SR_EXIT || state_r == PWR_PD_EXIT) begin
      illegal_nxt = !nop_like && cke_prev_r && link.cke;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < `NUM_BANKS; i++)
        bank_r[i] <= BANK_IDLE;
    end else if (decode_en && !illegal_nxt) begin
      for (int i = 0; i < `NUM_BANKS; i++) begin
        if (bank_r[i] == BANK_PRECHARGING)
          bank_r[i] <= BANK_IDLE;
      end
      case (cmd)
        CMD_ACTIVE: bank_r[link.bank_addr] <= BANK_OPEN;
        CMD_PRECHARGE: begin
          for (int i = 0; i < `NUM_BANKS; i++) begin
            // idle or precharging bank sees no operation
            if ((link.auto_pre || 2'(i) == link.bank_addr) &&
                bank_r[i] == BANK_OPEN)
              bank_r[i] <= BANK_PRECHARGING;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_valid_out <= 1'b0;
      cmd_out       <= CMD_DESELECT;
      cmd_bank_out  <= 2'h0;
      illegal_out   <= 1'b0;
    end else begin
      cmd_valid_out <= decode_en && !nop_like && !illegal_nxt;
      cmd_out       <= decode_en ? cmd : CMD_DESELECT;
      cmd_bank_out  <= link.bank_addr;
      illegal_out   <= illegal_nxt;
    end
  end

  assign pwr_state_out = state_r;

  always_comb begin
    for (int i = 0; i < `NUM_BANKS; i++)
      bank_open_out[i] = bank_r[i] == BANK_OPEN;
  end

endmodule

// ### rtl/cke_power_ctrl.sv
// controller-side cke and command driver with power-state sequencing
`timescale 1ns/1ps
`include "cke_power_map.svh"
module cke_power_ctrl
  import cke_power_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  cke_power_if.ctrl       link,
  input  wire logic       req_valid_in,
  input  cmd_t            req_cmd_in,
  input  wire logic [1:0] req_bank_in,
  input  wire logic       req_all_in,
  input  wire logic       pd_req_in,
  input  wire logic       sr_req_in,
  input  wire logic       wake_in,
  output logic            req_ready_out,
  output logic            refresh_due_out,
  output pwr_state_t      state_out
);

  pwr_state_t          state_r;
  logic [`CNT_W-1:0]   wait_r;
  logic [15:0]         pd_cnt_r;
  logic [3:0]          open_r;
  logic                issue;
  logic                all_idle;

  assign all_idle = open_r == 4'h0;
  assign req_ready_out = state_r == PWR_IDLE || state_r == PWR_ACTIVE;
  // never issue refresh or mode set with banks open
  assign issue = req_valid_in && req_ready_out && !pd_req_in && !sr_req_in &&
                 !((req_cmd_in == CMD_REFRESH || req_cmd_in == CMD_MRS) &&
                   !all_idle);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= PWR_IDLE;
      wait_r  <= '0;
      open_r  <= 4'h0;
    end else begin
      case (state_r)
        PWR_IDLE, PWR_ACTIVE: begin
          if (sr_req_in && all_idle)
            state_r <= PWR_SELF_REFRESH;
          else if (pd_req_in && all_idle)
            state_r <= PWR_POWER_DOWN;
          else if (issue && req_cmd_in == CMD_ACTIVE)
            open_r[req_bank_in] <= 1'b1;
          else if (issue && req_cmd_in == CMD_PRECHARGE)
            open_r <= req_all_in ? 4'h0 : open_r & ~(4'h1 << req_bank_in);
        end
        PWR_POWER_DOWN: begin
          // refresh due forces exit
          if (wake_in || refresh_due_out) begin
            state_r <= PWR_PD_EXIT;
            wait_r  <= `CNT_W'(`PD_EXIT_CYCLES - 1);
          end
        end
        PWR_SELF_REFRESH: begin
          if (wake_in) begin
            state_r <= PWR_SR_EXIT;
            wait_r  <= `CNT_W'(`SR_EXIT_CYCLES - 1);
          end
        end
        PWR_PD_EXIT, PWR_SR_EXIT: begin
          if (wait_r == '0)
            state_r <= PWR_IDLE;
          else
            wait_r <= wait_r - `CNT_W'(1);
        end
        default: state_r <= PWR_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      pd_cnt_r <= 16'h0;
    else if (state_r == PWR_POWER_DOWN)
      pd_cnt_r <= pd_cnt_r + 16'h1;
    else
      pd_cnt_r <= 16'h0;
  end

  assign refresh_due_out = pd_cnt_r >=
    16'(`REFRESH_PERIOD_CYCLES - `REFRESH_MARGIN_CYCLES);

  // command bus: nop during exits, burst turnaround left to the requester
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link.cke       <= 1'b1;
      link.cs_n      <= 1'b1;
      link.ras_n     <= 1'b1;
      link.cas_n     <= 1'b1;
      link.we_n      <= 1'b1;
      link.bank_addr <= 2'h0;
      link.auto_pre  <= 1'b0;
    end else begin
      link.cs_n      <= 1'b1;
      link.ras_n     <= 1'b1;
      link.cas_n     <= 1'b1;
      link.we_n      <= 1'b1;
      link.bank_addr <= req_bank_in;
      link.auto_pre  <= req_all_in;
      link.cke <= !(state_r == PWR_POWER_DOWN || state_r == PWR_SELF_REFRESH)
                  || wake_in || refresh_due_out;
      if (req_ready_out && sr_req_in && all_idle) begin
        link.cke   <= 1'b0;
        link.cs_n  <= 1'b0;
        link.ras_n <= 1'b0;
        link.cas_n <= 1'b0;
      end else if (req_ready_out && pd_req_in && all_idle) begin
        link.cke <= 1'b0;
      end else if (issue) begin
        link.cs_n <= 1'b0;
        case (req_cmd_in)
          CMD_ACTIVE:     {link.ras_n, link.cas_n, link.we_n} <= 3'h3;
          CMD_READ:       {link.ras_n, link.cas_n, link.we_n} <= 3'h5;
          CMD_WRITE:      {link.ras_n, link.cas_n, link.we_n} <= 3'h4;
          CMD_PRECHARGE:  {link.ras_n, link.cas_n, link.we_n} <= 3'h2;
          CMD_BURST_STOP: {link.ras_n, link.cas_n, link.we_n} <= 3'h6;
          CMD_REFRESH:    {link.ras_n, link.cas_n, link.we_n} <= 3'h1;
          CMD_MRS:        {link.ras_n, link.cas_n, link.we_n} <= 3'h0;
          default:        {link.ras_n, link.cas_n, link.we_n} <= 3'h7;
        endcase
      end
    end
  end

  assign state_out = state_r;

endmodule

// ### test/cke_power_assertions.sv
// concurrent checks on the cke power link and memory state
`timescale 1ns/1ps
module cke_power_assertions
  import cke_power_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       cke,
  input  wire logic       cs_n,
  input  wire logic       ras_n,
  input  wire logic       cas_n,
  input  wire logic       we_n,
  input  wire logic [1:0] bank_addr,
  input  wire logic       auto_pre,
  input  pwr_state_t      pwr_state_out,
  input  wire logic       rx_enabled_out,
  input  wire logic       cmd_valid_out,
  input  wire logic       illegal_out,
  input  wire logic [3:0] bank_open_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic nop_c;
  logic sr_c;
  assign nop_c = cs_n || (ras_n && cas_n && we_n);
  assign sr_c  = !cs_n && !ras_n && !cas_n && we_n;
  sequence sr_exit_s;
    (pwr_state_out == PWR_SR_EXIT) [*8];
  endsequence
  sequence back_idle_s;
    ##[1:12] (pwr_state_out == PWR_IDLE);
  endsequence
  a_sr_entry: assert property ($fell(cke) && sr_c |=>
    pwr_state_out == PWR_SELF_REFRESH) else $error("sr entry");
  a_pd_entry: assert property ($fell(cke) && nop_c |=>
    pwr_state_out == PWR_POWER_DOWN) else $error("pd entry");
  a_low_hold: assert property (!cke && !$past(cke) &&
    (pwr_state_out inside {PWR_POWER_DOWN, PWR_SELF_REFRESH}) |=>
    pwr_state_out == $past(pwr_state_out) && !cmd_valid_out
    && !illegal_out) else $error("low hold");
  a_pd_exit_time: assert property ($rose(cke) &&
    pwr_state_out == PWR_POWER_DOWN |=> pwr_state_out == PWR_PD_EXIT
    ##[1:3] (pwr_state_out inside {PWR_IDLE, PWR_ACTIVE}))
    else $error("pd exit");
  a_sr_exit_time: assert property ($rose(cke) &&
    pwr_state_out == PWR_SELF_REFRESH |=> sr_exit_s ##0 back_idle_s)
    else $error("sr exit");
  a_sr_wake_rx: assert property ($rose(cke) &&
    pwr_state_out == PWR_SELF_REFRESH |-> rx_enabled_out)
    else $error("rx wake");
  a_pd_rx_off: assert property (pwr_state_out == PWR_POWER_DOWN
    && !cke |-> !rx_enabled_out) else $error("rx off");
  a_exit_nop_only: assert property (pwr_state_out == PWR_SR_EXIT
    |-> nop_c) else $error("exit cmd");
  a_fall_legal: assert property ($fell(cke) |-> nop_c || sr_c)
    else $error("fall cmd");
  a_refresh_idle: assert property (cke && !cs_n && !ras_n &&
    !cas_n |-> bank_open_out == 4'h0) else $error("refresh open");
  a_decode_one: assert property (cke && $past(cke) && !cs_n &&
    !ras_n && cas_n && we_n && (pwr_state_out inside {PWR_IDLE,
    PWR_ACTIVE}) |=> cmd_valid_out != illegal_out) else $error("dec");
  a_prev_low_nodec: assert property (!$past(cke) |=> !cmd_valid_out)
    else $error("low decode");
  a_pre_closes: assert property (cke && $past(cke) && !cs_n &&
    !ras_n && cas_n && !we_n && (pwr_state_out inside {PWR_IDLE,
    PWR_ACTIVE}) |=> ($past(auto_pre) ? bank_open_out == 4'h0 :
    !bank_open_out[$past(bank_addr)])) else $error("pre close");
endmodule

// ### test/ddr_sdram_cke_power_state_control_tb.sv
// bench joining controller and memory ends over the cke link
`timescale 1ns/1ps
`include "cke_power_map.svh"
module ddr_sdram_cke_power_state_control_tb;
  import cke_power_pkg::*;
  logic       sys_clk_in, reset_n_in, req_valid, req_all, pd_req;
  logic       sr_req, wake, req_ready, refresh_due, rx_en, cmd_valid;
  logic       illegal;
  cmd_t       req_cmd, cmd_o, last_cmd;
  logic [1:0] req_bank, cmd_bank, last_bank;
  logic [3:0] bank_open, open_m;
  pwr_state_t mem_state, ctrl_state;
  int         err_count, n_compared, cycles, n_ill, n_val, i;
  cke_power_if link_if ();
  cke_power_ctrl u_cke_power_ctrl (.sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in), .link(link_if.ctrl), .req_valid_in(req_valid),
    .req_cmd_in(req_cmd), .req_bank_in(req_bank), .req_all_in(req_all),
    .pd_req_in(pd_req), .sr_req_in(sr_req), .wake_in(wake),
    .req_ready_out(req_ready), .refresh_due_out(refresh_due),
    .state_out(ctrl_state));
  cke_power_mem u_cke_power_mem (.sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in), .link(link_if.mem), .pwr_state_out(mem_state),
    .rx_enabled_out(rx_en), .cmd_valid_out(cmd_valid), .cmd_out(cmd_o),
    .cmd_bank_out(cmd_bank), .illegal_out(illegal),
    .bank_open_out(bank_open));
  cke_power_assertions u_chk (.sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in), .cke(link_if.cke), .cs_n(link_if.cs_n),
    .ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n),
    .bank_addr(link_if.bank_addr), .auto_pre(link_if.auto_pre),
    .pwr_state_out(mem_state), .rx_enabled_out(rx_en),
    .cmd_valid_out(cmd_valid), .illegal_out(illegal),
    .bank_open_out(bank_open));
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_state(input pwr_state_t got, input pwr_state_t exp);
    chk_val(8'(got), 8'(exp));
  endtask
  task automatic wait_state(input pwr_state_t s);
    for (int j = 0; j < 40 && mem_state !== s; j++) @(posedge sys_clk_in);
  endtask
  // edge monitor of decoded results, with the run limit
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cmd_valid === 1'b1) begin
      n_val++;
      last_cmd = cmd_o;
      last_bank = cmd_bank;
    end
    if (illegal === 1'b1) n_ill++;
    if (cycles > 10000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic issue(input cmd_t c, input logic [1:0] b, input logic a);
    int k, i0, v0;
    req_cmd   <= c;
    req_bank  <= b;
    req_all   <= a;
    req_valid <= 1'b1;
    @(posedge sys_clk_in);
    for (k = 0; k < 20 && req_ready !== 1'b1; k++) @(posedge sys_clk_in);
    req_valid <= 1'b0;
    i0 = n_ill;
    v0 = n_val;
    case (c)
      CMD_ACTIVE: begin
        k = open_m[b];
        open_m[b] = 1'b1;
      end
      CMD_READ, CMD_WRITE: k = open_m[b] ? 0 : 1;
      CMD_PRECHARGE: begin
        k = 2;
        if (a) open_m = 4'h0;
        else open_m[b] = 1'b0;
      end
      CMD_REFRESH, CMD_MRS: k = (open_m == 4'h0) ? 0 : 3;
      CMD_BURST_STOP: k = 4;
      default: k = 3;
    endcase
    repeat (4) @(posedge sys_clk_in);
    if (k == 0) chk_val(8'(last_cmd), 8'(c));
    if (k == 0) chk_val(8'(last_bank), 8'(b));
    if (k != 4) chk_val(8'(n_ill - i0), 8'(k == 1));
    if (k == 0 || k == 3) chk_val(8'(n_val - v0), 8'(k == 0));
    chk_val(8'(bank_open), 8'(open_m));
  endtask
  initial begin
    {req_valid, req_all, pd_req, sr_req, wake} <= 5'h00;
    req_cmd <= CMD_NOP;
    req_bank <= 2'h0;
    open_m = 4'h0;
    reset_n_in <= 1'b0;
    repeat (10) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    void'($urandom(32'hee2b42dd));
    @(posedge sys_clk_in);
    for (i = 0; i < 9; i++) issue(cmd_t'(i), 2'h1, 1'b0);
    $display("test 1 done");
    repeat (40)
      issue(cmd_t'(4'($urandom_range(8))), 2'($urandom), 1'($urandom));
    $display("test 2 done");
    issue(CMD_PRECHARGE, 2'h0, 1'b1);
    pd_req <= 1'b1;
    wait_state(PWR_POWER_DOWN);
    pd_req <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    chk_state(mem_state, PWR_POWER_DOWN);
    chk_val(8'(rx_en), 8'h0);
    chk_state(ctrl_state, PWR_POWER_DOWN);
    chk_val(8'(req_ready), 8'h0);
    for (i = 0; i < 1700 && refresh_due !== 1'b1; i++) @(posedge sys_clk_in);
    chk_val(8'(refresh_due), 8'h1);
    wake <= 1'b1;
    wait_state(PWR_IDLE);
    wake <= 1'b0;
    chk_state(mem_state, PWR_IDLE);
    $display("test 3 done");
    sr_req <= 1'b1;
    wait_state(PWR_SELF_REFRESH);
    sr_req <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    chk_state(mem_state, PWR_SELF_REFRESH);
    chk_state(ctrl_state, PWR_SELF_REFRESH);
    wake <= 1'b1;
    wait_state(PWR_SR_EXIT);
    for (i = 0; i < 40 && mem_state !== PWR_IDLE; i++) @(posedge sys_clk_in);
    wake <= 1'b0;
    chk_val(8'(i), 8'(`SR_EXIT_CYCLES));
    chk_state(ctrl_state, PWR_IDLE);
    issue(CMD_ACTIVE, 2'h2, 1'b0);
    $display("test 4 done");
    stop_test();
  end
endmodule
